/* File: verilog/ubsirq_core.sv */
/*
  UART buffer status, watermark interrupt selection and write-error logic.
  Assumes the shifters live outside: they report pops, pushes and
  stop-bit timing as single-cycle pulses on the same clock.
*/
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/10ps

// Summary of operation
// R1: TX select 111: irq at one free slot
// R2: RX select 111: irq when eight held
// R3: RX select 000: irq with any word
// R4: write while TX full sets sticky error
// R5: LIN/parity: write with zero field errs
// R6: stop mode picks RX irq timing
// R7: TX-empty write-one clears pointers when disabled
// R8: enabled parity/framing error blocks RX irq
// R9: RX overflow sets sticky flag
// R10: full flags track occupancy; defined reset values
module ubsirq_core
  import ubsirq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire ubs_req_t    req,
  output      logic [15:0] rdata,
  // Transmit side
  output      logic        tx_wr,
  output      logic [7:0]  tx_byte,
  input  wire logic        tx_pop,
  // Receive side
  input  wire ubs_rx_ev_t  rx_ev,
  input  wire logic [7:0]  rx_byte,
  output      logic [7:0]  rx_data,
  // Interrupt
  output      logic        irq
);

  logic [3:0]  tx_cnt_q, tx_cnt_d;
  logic [3:0]  rx_cnt_q, rx_cnt_d;
  logic [2:0]  tx_sel_q, rx_sel_q;
  logic        stop_detect_timing_sel_q, tx_write_error_flag_q;
  logic [5:0]  ctrl_q;
  logic [8:0]  param_q;
  logic [UBS_NEV-1:0] ev_st_q, ev_mk_q, ev_set;
  logic [15:0] rdata_q, stah;
  logic [7:0]  tx_byte_q, rx_data_q;
  logic [7:0]  rx_mem [UBS_DEPTH];
  logic [2:0]  rx_wp_q, rx_rp_q;
  logic        wr_stah, wr_data, rd_data, tx_reset, tx_err;
  logic        tx_full, rx_full, rx_wm, tx_wm, rx_time, rx_ovf;
  logic [3:0]  tx_free;

  // Register decode
  assign wr_stah = req.wr && req.addr == UBS_OFF_STAH;
  // Data window sits just above the mask register
  assign wr_data = req.wr && req.addr == UBS_OFF_IRQMK + 4'h1;
  assign rd_data = req.rd && req.addr == UBS_OFF_IRQMK + 4'h1;

  assign tx_full = tx_cnt_q == UBS_FULL; // [R10]
  assign rx_full = rx_cnt_q == UBS_FULL; // [R10]
  assign tx_free = UBS_FULL - tx_cnt_q;

  // Pointer reset only legal with transmitter off
  assign tx_reset = wr_stah && req.wdata[UBS_B_TXBE]
                    && !ctrl_q[UBS_B_TXEN]; // [R7]

  // A write into a full buffer, or with a zero field in LIN modes
  assign tx_err = wr_data && (tx_full
                  || (ctrl_q[UBS_B_LINP] && param_q == 9'h000)); // [R4] [R5]

  // Transmit occupancy; a refused write does not store
  always_comb begin
    tx_cnt_d = tx_cnt_q;
    if (tx_reset) begin
      tx_cnt_d = UBS_ZERO; // [R7]
    end else if (wr_data && !tx_err && !tx_pop) begin
      tx_cnt_d = tx_cnt_q + UBS_ONE;
    end else if (tx_pop && tx_cnt_q != UBS_ZERO
                 && !(wr_data && !tx_err)) begin
      tx_cnt_d = tx_cnt_q - UBS_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_cnt_q <= UBS_ZERO;
    end else begin
      tx_cnt_q <= tx_cnt_d;
    end
  end

  // Transmit byte handed to the shifter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_byte_q <= 8'h00;
      tx_wr     <= 1'b0;
    end else begin
      tx_wr <= wr_data && !tx_err;
      if (wr_data && !tx_err) begin
        tx_byte_q <= req.wdata[7:0];
      end
    end
  end
  assign tx_byte = tx_byte_q;

  // Receive store: overflow drops the new word
  assign rx_ovf = rx_ev.push && rx_full && !rd_data;
  always_comb begin
    rx_cnt_d = rx_cnt_q;
    if (rx_ev.push && !rx_full && !(rd_data && rx_cnt_q != UBS_ZERO)) begin
      rx_cnt_d = rx_cnt_q + UBS_ONE;
    end else if (rd_data && rx_cnt_q != UBS_ZERO && !rx_ev.push) begin
      rx_cnt_d = rx_cnt_q - UBS_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt_q  <= UBS_ZERO;
      rx_wp_q   <= 3'h0;
      rx_rp_q   <= 3'h0;
      rx_data_q <= 8'h00;
    end else begin
      rx_cnt_q <= rx_cnt_d;
      if (rx_ev.push && (!rx_full || rd_data)) begin
        rx_wp_q <= rx_wp_q + 3'h1;
      end
      if (rd_data && rx_cnt_q != UBS_ZERO) begin
        rx_rp_q   <= rx_rp_q + 3'h1;
        rx_data_q <= rx_mem[rx_rp_q];
      end
    end
  end
  assign rx_data = rx_data_q;

  // Receive array has no reset; contents are invalid until counted
  always_ff @(posedge clk) begin
    if (rx_ev.push && (!rx_full || rd_data)) begin
      rx_mem[rx_wp_q] <= rx_byte;
    end
  end

  // Control, parameter and select fields
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sel_q <= UBS_SEL_MIN;
      rx_sel_q <= UBS_SEL_MIN;
      stop_detect_timing_sel_q  <= 1'b0;
      ctrl_q   <= 6'h00;
      param_q  <= 9'h000;
    end else if (wr_stah) begin
      tx_sel_q <= req.wdata[UBS_B_TXSEL +: 3];
      rx_sel_q <= req.wdata[UBS_B_RXSEL +: 3];
      stop_detect_timing_sel_q  <= req.wdata[UBS_B_STOP_DETECT_TIMING_SEL];
    end else if (req.wr && req.addr == UBS_OFF_CTRL) begin
      ctrl_q <= req.wdata[5:0];
    end else if (req.wr && req.addr == UBS_OFF_PARAM) begin
      param_q <= req.wdata[8:0];
    end
  end

  // Write-error flag: set wins over software clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_write_error_flag_q <= 1'b0;
    end else if (tx_err) begin
      tx_write_error_flag_q <= 1'b1; // [R4] [R5]
    end else if (wr_stah && !req.wdata[UBS_B_TX_WRITE_ERROR_FLAG]) begin
      tx_write_error_flag_q <= 1'b0; // [R4]
    end
  end

  // Watermarks: code 111 is one free slot / full, else at least 8-N free (tx) / N+1 held (rx)
  always_comb begin
    if (tx_sel_q == UBS_SEL_MAX) begin
      tx_wm = tx_free == UBS_ONE; // [R1]
    end else begin
      tx_wm = tx_free >= UBS_FULL - {1'b0, tx_sel_q};
    end
    if (rx_sel_q == UBS_SEL_MAX) begin
      rx_wm = rx_full; // [R2]
    end else if (rx_sel_q == UBS_SEL_MIN) begin
      rx_wm = rx_cnt_q != UBS_ZERO; // [R3]
    end else begin
      rx_wm = rx_cnt_q >= {1'b0, rx_sel_q} + UBS_ONE;
    end
  end

  // Stop-bit timing picks the strobe that lets the rx irq fire
  assign rx_time = stop_detect_timing_sel_q ? rx_ev.end_stop : rx_ev.mid_stop; // [R6]

  // Events into the sticky status
  always_comb begin
    ev_set = '0;
    ev_set[UBS_EV_TX]   = tx_wm;
    ev_set[UBS_EV_RX]   = rx_wm && rx_time
      && !(rx_ev.perr && ctrl_q[UBS_B_PEIE])
      && !(rx_ev.ferr && ctrl_q[UBS_B_FEIE]); // [R8]
    ev_set[UBS_EV_TXWE] = tx_err;
    ev_set[UBS_EV_OVF]  = rx_ovf; // [R9]
  end

  // Sticky status, write one to clear; a new event wins
  for (genvar i = 0; i < UBS_NEV; i++) begin : g_ev
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ev_st_q[i] <= 1'b0;
      end else if (ev_set[i]) begin
        ev_st_q[i] <= 1'b1; // [R9]
      end else if (req.wr && req.addr == UBS_OFF_IRQST && req.wdata[i]) begin
        ev_st_q[i] <= 1'b0;
      end
    end
  end

  // Mask register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_mk_q <= '0;
    end else if (req.wr && req.addr == UBS_OFF_IRQMK) begin
      ev_mk_q <= req.wdata[UBS_NEV-1:0];
    end
  end

  assign irq = |(ev_st_q & ev_mk_q);

  // Status high image; empty/idle/resume read 1 out of reset
  always_comb begin
    stah = UBS_ZERO16;
    stah[UBS_B_TXSEL +: 3] = tx_sel_q;
    stah[UBS_B_RXSEL +: 3] = rx_sel_q;
    stah[UBS_B_TX_WRITE_ERROR_FLAG] = tx_write_error_flag_q;
    stah[UBS_B_STOP_DETECT_TIMING_SEL] = stop_detect_timing_sel_q;
    stah[UBS_B_TXBE]  = tx_cnt_q == UBS_ZERO; // [R7] [R10]
    stah[UBS_B_TXBF]  = tx_full; // [R10]
    stah[UBS_B_RECEIVER_IDLE_FLAG] = rx_ev.idle;
    stah[UBS_B_XON]   = rx_ev.flow_resume_flag;
    stah[UBS_B_RXBE]  = rx_cnt_q == UBS_ZERO; // [R10]
    stah[UBS_B_RXBF]  = rx_full; // [R10]
  end

  // Read data one cycle later; unmapped or empty data reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= UBS_ZERO16;
    end else if (req.rd) begin
      if (req.addr == UBS_OFF_STAH) begin
        rdata_q <= stah;
      end else if (req.addr == UBS_OFF_CTRL) begin
        rdata_q <= {10'h000, ctrl_q};
      end else if (req.addr == UBS_OFF_PARAM) begin
        rdata_q <= {7'h00, param_q};
      end else if (req.addr == UBS_OFF_IRQST) begin
        rdata_q <= {12'h000, ev_st_q};
      end else if (req.addr == UBS_OFF_IRQMK) begin
        rdata_q <= {12'h000, ev_mk_q};
      end else if (rd_data && rx_cnt_q != UBS_ZERO) begin
        rdata_q <= {8'h00, rx_mem[rx_rp_q]};
      end else begin
        rdata_q <= UBS_ZERO16;
      end
    end else begin
      rdata_q <= UBS_ZERO16;
    end
  end
  assign rdata = rdata_q;

  // Receive count never passes the depth
  rx_full_a: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
    rx_cnt_q <= UBS_FULL)
    else $error("rx count over depth");

  // Transmit count never passes the depth
  tx_bound_a: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
    tx_cnt_q <= UBS_FULL)
    else $error("tx count over depth");

  // Write to full buffer raises error next cycle
  tx_wre_a: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    (wr_data && tx_full) |=> tx_write_error_flag_q)
    else $error("no write error");

  // Error flag holds until software writes a zero to it
  tx_wre_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    (tx_write_error_flag_q && !(wr_stah && !req.wdata[UBS_B_TX_WRITE_ERROR_FLAG])) |=> tx_write_error_flag_q)
    else $error("write error dropped");

  // Zero parameter in LIN mode
  lin_err_a: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    (wr_data && ctrl_q[UBS_B_LINP] && param_q == 9'h000)
      |=> ev_st_q[UBS_EV_TXWE])
    else $error("lin err missed");

  // Overrun: a word arrives with eight held and none leaving
  sequence s_rx_overrun;
    rx_ev.push && rx_full && !rd_data;
  endsequence

  // Overflow bit set and software not clearing it this cycle
  sequence s_ovf_kept;
    ev_st_q[UBS_EV_OVF]
      && !(req.wr && req.addr == UBS_OFF_IRQST && req.wdata[UBS_EV_OVF]);
  endsequence

  // Overrun always reaches the sticky bit
  rx_ovf_a: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
    s_rx_overrun |=> ev_st_q[UBS_EV_OVF])
    else $error("ovf missed");

  // Overflow stays until cleared
  ovf_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
    s_ovf_kept |=> ev_st_q[UBS_EV_OVF])
    else $error("ovf dropped");

  // Pointer reset empties transmit
  tx_clr_a: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
    tx_reset |=> tx_cnt_q == UBS_ZERO)
    else $error("tx not reset");

  // Enabled parity error blocks rx event
  rx_mask_a: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    (rx_ev.perr && ctrl_q[UBS_B_PEIE]) |-> !ev_set[UBS_EV_RX])
    else $error("rx irq not blocked");

  // Enabled framing error blocks rx event
  rx_fmask_a: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    (rx_ev.ferr && ctrl_q[UBS_B_FEIE]) |-> !ev_set[UBS_EV_RX])
    else $error("rx irq not blocked");

  // Mode one ignores mid-stop strobe
  stop_sel_a: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
    (stop_detect_timing_sel_q && !rx_ev.end_stop) |-> !ev_set[UBS_EV_RX])
    else $error("rx irq wrong time");

  // Max code waits for full buffer
  rx_max_a: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    (rx_sel_q == UBS_SEL_MAX && !rx_full) |-> !rx_wm)
    else $error("rx wm early");

  // Min code fires with any word
  rx_min_a: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
    (rx_sel_q == UBS_SEL_MIN && rx_cnt_q != UBS_ZERO) |-> rx_wm)
    else $error("rx wm missed");

  // One free slot watermark
  tx_max_a: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    (tx_sel_q == UBS_SEL_MAX)
      |-> (tx_wm == (tx_cnt_q == UBS_FULL - UBS_ONE)))
    else $error("tx wm wrong");

endmodule : ubsirq_core

/* File: common/ubsirq_pkg.sv */
/*
  Package for the UART buffer status and interrupt select block.
  Holds register offsets, field positions, reset values and the
  packed types shared by the design. Assumes a 16-bit register port.
*/
package ubsirq_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] UBS_OFF_STAH  = 4'h0; // status high
  localparam logic [3:0] UBS_OFF_CTRL  = 4'h1; // mode and enables
  localparam logic [3:0] UBS_OFF_PARAM = 4'h2; // second parameter field
  localparam logic [3:0] UBS_OFF_IRQST = 4'h3; // sticky event status
  localparam logic [3:0] UBS_OFF_IRQMK = 4'h4; // event mask

  // Status high field positions
  localparam int UBS_B_TXSEL = 12;
  localparam int UBS_B_RXSEL = 8;
  localparam int UBS_B_TX_WRITE_ERROR_FLAG = 7;
  localparam int UBS_B_STOP_DETECT_TIMING_SEL = 6;
  localparam int UBS_B_TXBE  = 5;
  localparam int UBS_B_TXBF  = 4;
  localparam int UBS_B_RECEIVER_IDLE_FLAG = 3;
  localparam int UBS_B_XON   = 2;
  localparam int UBS_B_RXBE  = 1;
  localparam int UBS_B_RXBF  = 0;

  // Control register field positions
  localparam int UBS_B_TXEN  = 0; // transmit_enable_bit
  localparam int UBS_B_LINP  = 1; // LIN or parity mode
  localparam int UBS_B_PEIE  = 2; // parity error irq enable
  localparam int UBS_B_FEIE  = 3; // framing error irq enable
  localparam int UBS_B_STSL  = 4; // stop_bit_count_sel, 2 bits

  // Event bits in the sticky status and mask registers
  localparam int UBS_EV_TX   = 0;
  localparam int UBS_EV_RX   = 1;
  localparam int UBS_EV_TXWE = 2;
  localparam int UBS_EV_OVF  = 3;
  localparam int UBS_NEV     = 4;

  // Buffer geometry
  localparam int          UBS_DEPTH = 8;
  localparam logic [3:0]  UBS_FULL  = 4'h8;
  localparam logic [3:0]  UBS_ZERO  = 4'h0;
  localparam logic [3:0]  UBS_ONE   = 4'h1;

  // Watermark selector codes
  localparam logic [2:0] UBS_SEL_MIN = 3'h0;
  localparam logic [2:0] UBS_SEL_MAX = 3'h7;

  localparam logic [15:0] UBS_ZERO16 = 16'h0000;

  // Receive stream events from the shifter
  typedef struct packed {
    logic push;       // word received
    logic mid_stop;   // middle of the selected stop bit
    logic end_stop;   // end of the last stop bit
    logic perr;       // parity error flag
    logic ferr;       // framing error flag
    logic idle;       // receiver idle
    logic flow_resume_flag;        // flow resume state
  } ubs_rx_ev_t;

  // Register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } ubs_req_t;

endpackage : ubsirq_pkg

/* File: dv/ubsirq_partner.sv */
/*
  Far-side model: transmit and receive shifters of the UART.
  Assumes one clock shared with the status block.
*/
`timescale 1ns/10ps
module ubsirq_partner
  import ubsirq_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Transmit side
  input  wire logic       tx_wr,
  input  wire logic       drain,
  output      logic       tx_pop,
  // Receive side
  input  wire logic [1:0] rx_go,
  input  wire logic       perr,
  input  wire logic       ferr,
  output      ubs_rx_ev_t rx_ev,
  output      logic [7:0] rx_byte
);
  logic [3:0] held_q;
  logic [1:0] stb_q;
  logic [1:0] stp_q;
  logic       push_q;
  logic [7:0] byte_q;

  // Never pops an empty buffer; count follows accepted bytes
  assign tx_pop = drain && (held_q != 4'h0);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) held_q <= 4'h0;
    else held_q <= held_q + 4'(tx_wr) - 4'(tx_pop);
  end

  // Word, then stop strobes a cycle later; may overrun on purpose
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {push_q, stb_q, stp_q, byte_q} <= '0;
    end else begin
      push_q <= rx_go != 2'h0;
      stb_q  <= rx_go;
      stp_q  <= stb_q;
      if (push_q) byte_q <= byte_q + 8'h01;
    end
  end

  // Data line shows the inverse of the next word outside a push
  assign rx_byte = push_q ? byte_q : ~byte_q;
  assign rx_ev   = '{push_q, stp_q[0], stp_q[1], perr, ferr, 1'b1, 1'b1};
endmodule : ubsirq_partner

/* File: dv/uart_buffer_status_irq_select_tb_top.sv */
/*
  Testbench for the status and watermark interrupt block.
  Assumes the core answers reads one cycle later and never stalls.
*/
`timescale 1ns/10ps
module uart_buffer_status_irq_select_tb_top
  import ubsirq_pkg::*;
;
  localparam logic [3:0] OFF_DATA = 4'h5;
  logic        clk;
  logic        rst_n;
  ubs_req_t    req;
  logic [15:0] rdata;
  logic        tx_wr;
  logic [7:0]  tx_byte;
  logic        tx_pop;
  ubs_rx_ev_t  rx_ev;
  logic [7:0]  rx_byte;
  logic [7:0]  rx_data;
  logic        irq;
  logic        drain;
  logic [1:0]  rx_go;
  logic        perr;
  logic        ferr;
  int          n_txwr;
  int          error_cnt;
  int          total_checks;
  int          cyc;
  logic [15:0] v;

  ubsirq_core i_ubsirq_core (.clk(clk), .rst_n(rst_n), .req(req),
    .rdata(rdata), .tx_wr(tx_wr), .tx_byte(tx_byte), .tx_pop(tx_pop),
    .rx_ev(rx_ev), .rx_byte(rx_byte), .rx_data(rx_data), .irq(irq));
  ubsirq_partner i_ubsirq_partner (.clk(clk), .rst_n(rst_n),
    .tx_wr(tx_wr), .drain(drain), .tx_pop(tx_pop), .rx_go(rx_go),
    .perr(perr), .ferr(ferr), .rx_ev(rx_ev), .rx_byte(rx_byte));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  // Hang guard well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end

  // Accepted bytes handed to the shifter since the last reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) n_txwr <= 0;
    else if (tx_wr) n_txwr <= n_txwr + 1;
  end

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd

  task automatic rx_word(input logic [1:0] stb);
    @(posedge clk);
    rx_go <= stb;
    @(posedge clk);
    rx_go <= 2'h0;
    repeat (4) @(posedge clk);
  endtask : rx_word

  initial begin
    {rst_n, drain, rx_go, perr, ferr, error_cnt, total_checks, cyc} = '0;
    req = '0;
    do_reset();
    rd(UBS_OFF_STAH, v); chk(v, 16'h002E);
    // Two bytes out, far side drains them
    wr(OFF_DATA, 16'h00A5);
    wr(OFF_DATA, 16'h005A);
    drain <= 1'b1;
    repeat (4) @(posedge clk);
    drain <= 1'b0;
    rd(UBS_OFF_STAH, v); chk(v, 16'h002E);
    chk(16'(tx_byte), 16'h005A);
    // Transmit watermark at one free slot, then a write into the full buffer
    wr(UBS_OFF_IRQMK, 16'h000F);
    wr(UBS_OFF_STAH, 16'h7000);
    wr(UBS_OFF_IRQST, 16'h000F);
    for (int i = 0; i < 9; i++) begin
      wr(OFF_DATA, 16'(i));
      rd(UBS_OFF_IRQST, v);
      if (i == 5) chk(v, 16'h0000);
      if (i == 6) chk(v, 16'h0001);
    end
    chk(v, 16'h0005);
    chk(16'(irq), 16'h0001);
    chk(16'(n_txwr), 16'h000A);
    chk(16'(tx_byte), 16'h0007);
    rd(UBS_OFF_STAH, v); chk(v, 16'h709E);
    // Transmit on: the write-one leaves the buffer alone
    wr(UBS_OFF_CTRL, 16'h0001);
    wr(UBS_OFF_STAH, 16'h70A0);
    rd(UBS_OFF_STAH, v); chk(v, 16'h709E);
    wr(UBS_OFF_CTRL, 16'h0000);
    // Write-one to empty flag with transmit off clears the buffer
    wr(UBS_OFF_STAH, 16'h0020);
    rd(UBS_OFF_STAH, v); chk(v, 16'h002E);
    do_reset();
    // Zero parameter field refuses the byte in LIN/parity mode
    wr(UBS_OFF_CTRL, 16'h0002);
    wr(OFF_DATA, 16'h0055);
    rd(UBS_OFF_STAH, v); chk(v, 16'h00AE);
    chk(16'(tx_byte), 16'h0000);
    wr(UBS_OFF_PARAM, 16'h0001);
    wr(UBS_OFF_STAH, 16'h0000);
    wr(OFF_DATA, 16'h0055);
    rd(UBS_OFF_STAH, v); chk(v, 16'h000E);
    chk(16'(tx_byte), 16'h0055);
    do_reset();
    // Receive: any word raises the event; tx bits are masked out
    wr(UBS_OFF_IRQMK, 16'h000A);
    rx_word(2'h1);
    rd(UBS_OFF_IRQST, v); chk(v & 16'h000A, 16'h0002);
    chk(16'(irq), 16'h0001);
    rd(OFF_DATA, v); chk(16'(rx_data), 16'h0000);
    wr(UBS_OFF_IRQST, 16'h000F);
    // Enabled parity error blocks the event
    wr(UBS_OFF_CTRL, 16'h0004);
    perr <= 1'b1;
    rx_word(2'h1);
    rd(UBS_OFF_IRQST, v); chk(v & 16'h000A, 16'h0000);
    chk(16'(irq), 16'h0000);
    perr <= 1'b0;
    // Enabled framing error blocks the event as well
    wr(UBS_OFF_CTRL, 16'h0008);
    ferr <= 1'b1;
    rx_word(2'h1);
    rd(UBS_OFF_IRQST, v); chk(v & 16'h000A, 16'h0000);
    ferr <= 1'b0;
    wr(UBS_OFF_CTRL, 16'h0000);
    rd(OFF_DATA, v);
    rd(OFF_DATA, v); chk(16'(rx_data), 16'h0002);
    // End-of-stop timing ignores the mid-stop strobe
    wr(UBS_OFF_STAH, 16'h0040);
    rx_word(2'h1);
    rd(UBS_OFF_IRQST, v); chk(v & 16'h000A, 16'h0000);
    rx_word(2'h2);
    rd(UBS_OFF_IRQST, v); chk(v & 16'h000A, 16'h0002);
    do_reset();
    // Code 001 waits for a second word
    wr(UBS_OFF_STAH, 16'h0100);
    rx_word(2'h3);
    rd(UBS_OFF_IRQST, v); chk(v & 16'h000A, 16'h0000);
    rx_word(2'h3);
    rd(UBS_OFF_IRQST, v); chk(v & 16'h000A, 16'h0002);
    // Full-buffer watermark, then overflow stays until cleared
    wr(UBS_OFF_STAH, 16'h0700);
    wr(UBS_OFF_IRQST, 16'h000F);
    for (int i = 2; i < 8; i++) begin
      rx_word(2'h3);
      rd(UBS_OFF_IRQST, v);
      if (i == 6) chk(v & 16'h000A, 16'h0000);
    end
    chk(v & 16'h000A, 16'h0002);
    rd(UBS_OFF_STAH, v); chk(v, 16'h072D);
    rx_word(2'h3);
    rd(UBS_OFF_IRQST, v); chk(v & 16'h000A, 16'h000A);
    wr(UBS_OFF_IRQST, 16'h0008);
    rd(UBS_OFF_IRQST, v); chk(v & 16'h000A, 16'h0002);
    summarize();
  end
endmodule : uart_buffer_status_irq_select_tb_top
